// ===== rfc_converter.sv
// Our own choices: strobed register access and the placing of the registers.
module rfc_converter (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // Register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    // Clock sources and debug
    input  wire logic [3:0]  clk_src_tick_i,
    input  wire logic        debug_mode_i,
    // Sensor and reference pins
    output logic             reference_pin_o,
    output logic             reference_pin_oe_n_o,
    output logic             sensor_a_pin_o,
    output logic             sensor_a_pin_oe_n_o,
    output logic             sensor_b_pin_o,
    output logic             sensor_b_pin_oe_n_o,
    // Oscillation input pin
    input  wire logic        oscillation_input_pin_i,
    output logic             oscillation_input_pin_o,
    output logic             oscillation_input_pin_oe_n_o,
    // Monitor output pin
    output logic             oscillation_monitor_out_o,
    output logic             oscillation_monitor_out_oe_n_o,
    // Interrupt request
    output logic             irq_o
);

    // Configuration and state
    logic [1:0]              clock_source_select_r;
    logic [1:0]              clock_divide_select_r;
    logic                    run_in_debug_r;
    logic                    en_r;
    logic                    cont_r;
    logic                    ext_r;
    logic                    mon_r;
    logic                    ac_r;
    rfc_pkg::rfc_state_t     state_r;
    rfc_pkg::rfc_state_t     state_nxt;
    logic [23:0]             measurement_count_r;
    logic [23:0]             measurement_count_nxt;
    logic [23:0]             time_base_count_r;
    logic [23:0]             time_base_count_nxt;
    logic [4:0]              flags_r;
    logic [4:0]              flags_nxt;
    logic [4:0]              inte_r;
    logic [31:0]             rdata_r;
    logic                    osc_s1_r;
    logic                    osc_s2_r;
    logic                    osc_s3_r;
    logic                    ref_o_r;
    logic                    ref_oe_n_r;
    logic                    sena_o_r;
    logic                    sena_oe_n_r;
    logic                    senb_o_r;
    logic                    senb_oe_n_r;
    logic                    rfin_oe_n_r;
    logic                    mon_o_r;
    logic                    mon_oe_n_r;

    // Decode
    wire run      = ~debug_mode_i | run_in_debug_r;
    wire wr_clk   = wr_i & (addr_i == rfc_pkg::RFC_OFS_CLK);
    wire wr_ctl   = wr_i & (addr_i == rfc_pkg::RFC_OFS_CTL);
    wire wr_trg   = wr_i & (addr_i == rfc_pkg::RFC_OFS_TRG);
    wire wr_mc    = wr_i & (addr_i == rfc_pkg::RFC_OFS_MC);
    wire wr_tc    = wr_i & (addr_i == rfc_pkg::RFC_OFS_TC);
    wire wr_intf  = wr_i & (addr_i == rfc_pkg::RFC_OFS_INTF);
    wire wr_inte  = wr_i & (addr_i == rfc_pkg::RFC_OFS_INTE);
    wire ref_act  = (state_r == rfc_pkg::RFC_REF);
    wire sena_act = (state_r == rfc_pkg::RFC_SENA);
    wire senb_act = (state_r == rfc_pkg::RFC_SENB);
    wire busy     = ref_act | sena_act | senb_act;
    wire sens     = sena_act | senb_act;
    wire osc_clk  = osc_s2_r;
    wire osc_rise = osc_s2_r & ~osc_s3_r;

    // Operating clock
    logic time_base_clock;

    rfc_tb_div u_div (
        .clk_i      (clk_i),
        .rstn_i     (rstn_i),
        .run_i      (run),
        .src_tick_i (clk_src_tick_i),
        .src_sel_i  (clock_source_select_r),
        .div_sel_i  (clock_divide_select_r),
        .tick_o     (time_base_clock)
    );

    // Counting terms
    wire count_en  = run & busy & ~cont_r;
    wire mc_inc    = count_en & osc_rise;
    wire mc_wrap   = mc_inc & (measurement_count_r == rfc_pkg::RFC_CNT_MAX);
    wire tc_up     = count_en & ref_act & time_base_clock;
    wire tc_wrap   = tc_up & (time_base_count_r == rfc_pkg::RFC_CNT_MAX);
    wire tc_zero   = (time_base_count_r == rfc_pkg::RFC_CNT_ZERO);
    wire tc_dn     = count_en & sens & time_base_clock & ~tc_zero;
    wire sens_end  = count_en & sens & (tc_zero | (tc_dn & (time_base_count_r == rfc_pkg::RFC_CNT_ONE)));
    wire ref_end   = ref_act & (mc_wrap | tc_wrap);
    wire can_start = wr_trg & en_r & run & ~busy;
    wire go_ref    = can_start & wdata_i[rfc_pkg::RFC_TRG_REF_BIT];
    wire go_sena   = can_start & wdata_i[rfc_pkg::RFC_TRG_SENA_BIT];
    wire go_senb   = can_start & wdata_i[rfc_pkg::RFC_TRG_SENB_BIT] & ~ac_r;
    wire abort     = wr_trg & run & busy
                   & ~(ref_act  & wdata_i[rfc_pkg::RFC_TRG_REF_BIT])
                   & ~(sena_act & wdata_i[rfc_pkg::RFC_TRG_SENA_BIT])
                   & ~(senb_act & wdata_i[rfc_pkg::RFC_TRG_SENB_BIT]);
    wire cnt_wr_ok = run & ~busy;

    // Interrupt causes
    wire [4:0] flag_set = {tc_wrap,
                           mc_wrap & sens,
                           sens_end & senb_act,
                           sens_end & sena_act,
                           mc_wrap & ref_act};
    wire [4:0] flag_clr = wr_intf ? wdata_i[4:0] : 5'h00;

    // Sequencer
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            rfc_pkg::RFC_IDLE: begin
                if (go_ref) begin
                    state_nxt = rfc_pkg::RFC_REF;
                end else if (go_sena) begin
                    state_nxt = rfc_pkg::RFC_SENA;
                end else if (go_senb) begin
                    state_nxt = rfc_pkg::RFC_SENB;
                end
            end
            rfc_pkg::RFC_REF: begin
                if (ref_end | abort) begin
                    state_nxt = rfc_pkg::RFC_IDLE;
                end
            end
            rfc_pkg::RFC_SENA, rfc_pkg::RFC_SENB: begin
                if (sens_end | mc_wrap | abort) begin
                    state_nxt = rfc_pkg::RFC_IDLE;
                end
            end
        endcase
        if (!en_r & run) begin
            state_nxt = rfc_pkg::RFC_IDLE;
        end
    end

    // Counter next values: the count carries over from reference to sensor phase
    assign measurement_count_nxt = (wr_mc & cnt_wr_ok) ? wdata_i[23:0] :
                                   mc_inc ? measurement_count_r + 24'h000001 :
                                   measurement_count_r;
    assign time_base_count_nxt   = (wr_tc & cnt_wr_ok) ? wdata_i[23:0] :
                                   tc_up ? time_base_count_r + 24'h000001 :
                                   tc_dn ? time_base_count_r - 24'h000001 :
                                   time_base_count_r;
    assign flags_nxt             = (flags_r & ~flag_clr) | flag_set;

    // Synchroniser for the oscillation clock
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            osc_s1_r <= 1'b0;
            osc_s2_r <= 1'b0;
            osc_s3_r <= 1'b0;
        end else begin
            osc_s1_r <= oscillation_input_pin_i;
            osc_s2_r <= osc_s1_r;
            osc_s3_r <= osc_s2_r;
        end
    end

    // Software configuration
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            clock_source_select_r <= rfc_pkg::RFC_SRC_RST;
            clock_divide_select_r <= rfc_pkg::RFC_DIV_RST;
            run_in_debug_r        <= 1'b0;
        end else if (wr_clk & ~busy) begin
            clock_source_select_r <= wdata_i[rfc_pkg::RFC_CLK_SRC_LSB +: 2];
            clock_divide_select_r <= wdata_i[rfc_pkg::RFC_CLK_DIV_LSB +: 2];
            run_in_debug_r        <= wdata_i[rfc_pkg::RFC_CLK_DBG_BIT];
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            en_r   <= 1'b0;
            cont_r <= 1'b0;
            ext_r  <= 1'b0;
            mon_r  <= 1'b0;
            ac_r   <= 1'b0;
        end else if (wr_ctl & ~busy) begin
            en_r   <= wdata_i[rfc_pkg::RFC_CTL_EN_BIT];
            cont_r <= wdata_i[rfc_pkg::RFC_CTL_CONT_BIT];
            ext_r  <= wdata_i[rfc_pkg::RFC_CTL_EXT_BIT];
            mon_r  <= wdata_i[rfc_pkg::RFC_CTL_MON_BIT];
            ac_r   <= wdata_i[rfc_pkg::RFC_CTL_AC_BIT];
        end
    end

    // Converter state, frozen while the operating clock is gated
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r             <= rfc_pkg::RFC_IDLE;
            measurement_count_r <= rfc_pkg::RFC_CNT_ZERO;
            time_base_count_r   <= rfc_pkg::RFC_CNT_ZERO;
        end else if (run) begin
            state_r             <= state_nxt;
            measurement_count_r <= measurement_count_nxt;
            time_base_count_r   <= time_base_count_nxt;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flags_r <= rfc_pkg::RFC_FLAG_RST;
            inte_r  <= rfc_pkg::RFC_FLAG_RST;
        end else begin
            flags_r <= flags_nxt;
            if (wr_inte) begin
                inte_r <= wdata_i[4:0];
            end
        end
    end

    // Pin drive: the active pin feeds back the inverted clock, AC adds the opposite phase
    wire drv_ok    = en_r & ~ext_r;
    wire ref_drv   = drv_ok & (ref_act | (ac_r & sena_act));
    wire sena_drv  = drv_ok & (sena_act | (ac_r & ref_act));
    wire senb_drv  = drv_ok & ~ac_r & senb_act;
    wire rfin_drv  = en_r & ~busy;
    wire mon_drv   = en_r & (mon_r | cont_r);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ref_o_r     <= 1'b0;
            ref_oe_n_r  <= 1'b1;
            sena_o_r    <= 1'b0;
            sena_oe_n_r <= 1'b1;
            senb_o_r    <= 1'b0;
            senb_oe_n_r <= 1'b1;
            rfin_oe_n_r <= 1'b1;
            mon_o_r     <= 1'b0;
            mon_oe_n_r  <= 1'b1;
        end else if (run) begin
            ref_o_r     <= ref_act ? ~osc_clk : osc_clk;
            ref_oe_n_r  <= ~ref_drv;
            sena_o_r    <= sena_act ? ~osc_clk : osc_clk;
            sena_oe_n_r <= ~sena_drv;
            senb_o_r    <= ~osc_clk;
            senb_oe_n_r <= ~senb_drv;
            rfin_oe_n_r <= ~rfin_drv;
            mon_o_r     <= osc_clk;
            mon_oe_n_r  <= ~mon_drv;
        end
    end

    // Read path
    wire [31:0] rd_clk  = {23'h0, run_in_debug_r, 2'h0, clock_divide_select_r,
                           2'h0, clock_source_select_r};
    wire [31:0] rd_ctl  = {27'h0, ac_r, mon_r, ext_r, cont_r, en_r};
    wire [31:0] rd_trg  = {29'h0, senb_act, sena_act, ref_act};
    wire [31:0] rd_val  = (addr_i == rfc_pkg::RFC_OFS_CLK)  ? rd_clk :
                          (addr_i == rfc_pkg::RFC_OFS_CTL)  ? rd_ctl :
                          (addr_i == rfc_pkg::RFC_OFS_TRG)  ? rd_trg :
                          (addr_i == rfc_pkg::RFC_OFS_MC)   ? {8'h0, measurement_count_r} :
                          (addr_i == rfc_pkg::RFC_OFS_TC)   ? {8'h0, time_base_count_r} :
                          (addr_i == rfc_pkg::RFC_OFS_INTF) ? {27'h0, flags_r} :
                          (addr_i == rfc_pkg::RFC_OFS_INTE) ? {27'h0, inte_r} : 32'h0;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_r <= 32'h0;
        end else begin
            rdata_r <= rd_i ? rd_val : 32'h0;
        end
    end

    assign rdata_o                        = rdata_r;
    assign irq_o                          = |(flags_r & inte_r);
    assign reference_pin_o                = ref_o_r;
    assign reference_pin_oe_n_o           = ref_oe_n_r;
    assign sensor_a_pin_o                 = sena_o_r;
    assign sensor_a_pin_oe_n_o            = sena_oe_n_r;
    assign sensor_b_pin_o                 = senb_o_r;
    assign sensor_b_pin_oe_n_o            = senb_oe_n_r;
    assign oscillation_input_pin_o        = 1'b0;
    assign oscillation_input_pin_oe_n_o   = rfin_oe_n_r;
    assign oscillation_monitor_out_o      = mon_o_r;
    assign oscillation_monitor_out_oe_n_o = mon_oe_n_r;

    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    a_mc_counts_up: assert property (
        mc_inc & ~(wr_mc & cnt_wr_ok) |=> measurement_count_r == $past(measurement_count_r) + 24'h1
    ) else $error("measurement count did not step");

    a_tc_counts_up: assert property (
        tc_up |=> time_base_count_r == $past(time_base_count_r) + 24'h1
    ) else $error("time base did not count up");

    a_tc_counts_down: assert property (
        tc_dn |=> time_base_count_r == $past(time_base_count_r) - 24'h1
    ) else $error("time base did not count down");

    a_ref_wrap_stop: assert property (
        ref_act & en_r & (mc_wrap | tc_wrap) |=> state_r == rfc_pkg::RFC_IDLE && !rd_trg[0]
    ) else $error("reference did not stop on wrap");

    a_ref_done_flag: assert property (
        ref_act & mc_wrap |=> flags_r[rfc_pkg::RFC_F_REF] && !flags_r[rfc_pkg::RFC_F_OVMC]
    ) else $error("reference done flag missing");

    a_tb_ovf_flag: assert property (
        tc_wrap |=> flags_r[rfc_pkg::RFC_F_OVTC] ##1 !irq_o || inte_r != 5'h00
    ) else $error("time base overflow flag missing");

    a_sens_zero_stop: assert property (
        tc_dn & (time_base_count_r == rfc_pkg::RFC_CNT_ONE) & en_r
        |=> state_r == rfc_pkg::RFC_IDLE && time_base_count_r == rfc_pkg::RFC_CNT_ZERO
    ) else $error("sensor phase did not end at zero");

    a_debug_freeze: assert property (
        !run |=> $stable(measurement_count_r) && $stable(time_base_count_r)
                 && $stable(reference_pin_oe_n_o) && $stable(oscillation_monitor_out_oe_n_o)
    ) else $error("state moved while clock gated");

    a_run_in_debug: assert property (
        debug_mode_i & run_in_debug_r & tc_up |=> time_base_count_r != $past(time_base_count_r)
    ) else $error("converter halted despite run in debug");

    a_rfin_ground: assert property (
        $rose(en_r) & ~busy |=> !oscillation_input_pin_oe_n_o && !oscillation_input_pin_o
    ) else $error("input pin not grounded on enable");

    a_pins_idle_hiz: assert property (
        run & ~busy & ~$past(busy) |=> reference_pin_oe_n_o && sensor_a_pin_oe_n_o
                                       && sensor_b_pin_oe_n_o
    ) else $error("drive pin active while idle");

    a_monitor_drive: assert property (
        run & en_r & mon_r |=> !oscillation_monitor_out_oe_n_o
                               && oscillation_monitor_out_o == $past(osc_s2_r)
    ) else $error("monitor pin not showing clock");

    c_ref_done: cover property (ref_act ##[1:300] flags_r[rfc_pkg::RFC_F_REF]);
    c_sens_a_done: cover property (sena_act ##[1:300] flags_r[rfc_pkg::RFC_F_SENA]);
    c_tb_ovf: cover property (tc_wrap);
    c_debug_hold: cover property (busy & !run ##1 busy & run);

endmodule // rfc_converter

// ===== rfc_pkg.sv
package rfc_pkg;

    // Widths
    localparam int unsigned RFC_ADDR_W = 8;
    localparam int unsigned RFC_DATA_W = 32;
    localparam int unsigned RFC_CNT_W  = 24;
    localparam int unsigned RFC_NFLAG  = 5;
    localparam int unsigned RFC_DIV_W  = 3;

    // Register offsets
    localparam logic [7:0] RFC_OFS_CLK  = 8'h00;
    localparam logic [7:0] RFC_OFS_CTL  = 8'h04;
    localparam logic [7:0] RFC_OFS_TRG  = 8'h08;
    localparam logic [7:0] RFC_OFS_MC   = 8'h0c;
    localparam logic [7:0] RFC_OFS_TC   = 8'h10;
    localparam logic [7:0] RFC_OFS_INTF = 8'h14;
    localparam logic [7:0] RFC_OFS_INTE = 8'h18;

    // Clock register fields
    localparam int unsigned RFC_CLK_SRC_LSB = 0;
    localparam int unsigned RFC_CLK_DIV_LSB = 4;
    localparam int unsigned RFC_CLK_DBG_BIT = 8;

    // Control register fields
    localparam int unsigned RFC_CTL_EN_BIT   = 0;
    localparam int unsigned RFC_CTL_CONT_BIT = 1;
    localparam int unsigned RFC_CTL_EXT_BIT  = 2;
    localparam int unsigned RFC_CTL_MON_BIT  = 3;
    localparam int unsigned RFC_CTL_AC_BIT   = 4;

    // Trigger register fields
    localparam int unsigned RFC_TRG_REF_BIT  = 0;
    localparam int unsigned RFC_TRG_SENA_BIT = 1;
    localparam int unsigned RFC_TRG_SENB_BIT = 2;

    // Flag and enable bit positions
    localparam int unsigned RFC_F_REF  = 0;
    localparam int unsigned RFC_F_SENA = 1;
    localparam int unsigned RFC_F_SENB = 2;
    localparam int unsigned RFC_F_OVMC = 3;
    localparam int unsigned RFC_F_OVTC = 4;

    // Reset values and counter limits
    localparam logic [1:0]  RFC_SRC_RST  = 2'h0;
    localparam logic [1:0]  RFC_DIV_RST  = 2'h0;
    localparam logic [23:0] RFC_CNT_ZERO = 24'h000000;
    localparam logic [23:0] RFC_CNT_ONE  = 24'h000001;
    localparam logic [23:0] RFC_CNT_MAX  = 24'hffffff;
    localparam logic [4:0]  RFC_FLAG_RST = 5'h00;

    // Divider terminal counts for ratios 1/1, 1/2, 1/4, 1/8
    localparam logic [2:0] RFC_DIV_LIM [4] = '{3'h0, 3'h1, 3'h3, 3'h7};

    typedef enum logic [1:0] {
        RFC_IDLE,
        RFC_REF,
        RFC_SENA,
        RFC_SENB
    } rfc_state_t;

endpackage

// ===== rfc_sensor_model.sv
// Resistor network at the oscillation pin: same period for reference and sensors
module rfc_sensor_model #(
    parameter int unsigned HALF_NS = 300
) (
    // Pin drive from the converter
    input  wire logic in_oe_n_i,
    input  wire logic in_drv_i,
    // Resolved pin level
    output logic      pin_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic osc = 1'b0;

    // Released pin keeps toggling, never holds a stale level
    always #(HALF_NS) osc = ~osc;

    assign pin_o = in_oe_n_i ? osc : in_drv_i;
endmodule // rfc_sensor_model

// ===== rfc_tb_div.sv
module rfc_tb_div (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    // Control
    input  wire logic       run_i,
    input  wire logic [3:0] src_tick_i,
    input  wire logic [1:0] src_sel_i,
    input  wire logic [1:0] div_sel_i,
    // Divided tick
    output logic            tick_o
);

    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    logic [2:0] lim;
    logic       pick;
    logic       hit;

    assign pick    = src_tick_i[src_sel_i] & run_i;
    assign lim     = rfc_pkg::RFC_DIV_LIM[div_sel_i];
    assign hit     = (cnt_r >= lim);
    assign cnt_nxt = hit ? 3'h0 : cnt_r + 3'h1;
    assign tick_o  = pick & hit;

    // Divider halts while the converter clock is gated
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r <= 3'h0;
        end else if (pick) begin
            cnt_r <= cnt_nxt;
        end
    end

endmodule // rfc_tb_div

// ===== tb_rf_converter_counter_control.sv
module tb_rf_converter_counter_control;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic        dbg = 1'b0;
    logic        ref_d, ref_oe_n, sa_d, sa_oe_n, sb_d, sb_oe_n;
    logic        in_pin, in_drv, in_oe_n, mon, mon_oe_n, irq;
    logic [31:0] v, t1;
    int          error_cnt = 0;
    int          compares = 0;
    int          cyc = 0;

    always #50 clk_i = ~clk_i;

    rfc_converter i_dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .clk_src_tick_i(4'hf), .debug_mode_i(dbg),
        .reference_pin_o(ref_d), .reference_pin_oe_n_o(ref_oe_n),
        .sensor_a_pin_o(sa_d), .sensor_a_pin_oe_n_o(sa_oe_n),
        .sensor_b_pin_o(sb_d), .sensor_b_pin_oe_n_o(sb_oe_n),
        .oscillation_input_pin_i(in_pin), .oscillation_input_pin_o(in_drv),
        .oscillation_input_pin_oe_n_o(in_oe_n),
        .oscillation_monitor_out_o(mon), .oscillation_monitor_out_oe_n_o(mon_oe_n), .irq_o(irq)
    );

    rfc_sensor_model i_model (.in_oe_n_i(in_oe_n), .in_drv_i(in_drv), .pin_o(in_pin));

    task automatic print_verdict();
        if (error_cnt == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            print_verdict();
        end
    end

    task automatic cmp_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cmp_near(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if ((^got === 1'bx) || (got + 32'h2 < exp) || (got > exp + 32'h2)) begin
            error_cnt++;
            $display("CHECK FAILED %s expected about %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_i);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        #1 cmp_val("irq", 32'h1, {31'h0, irq});
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        for (int i = 0; i <= 8'h1c; i += 4) begin
            rd_reg(i[7:0], v);
            cmp_val("reset read", 32'h0, v);
        end
        cmp_val("pins hi-z", 32'h1, {31'h0, ref_oe_n & sa_oe_n & sb_oe_n & mon_oe_n});
        wr_reg(rfc_pkg::RFC_OFS_INTE, 32'h1f);
        wr_reg(rfc_pkg::RFC_OFS_CTL, 32'h1);
        @(posedge clk_i);
        #1 cmp_val("input grounded", 32'h0, {31'h0, in_oe_n});
        cmp_val("ref idle", 32'h1, {31'h0, ref_oe_n});
        wr_reg(rfc_pkg::RFC_OFS_MC, 32'h00fffff0);
        wr_reg(rfc_pkg::RFC_OFS_TC, 32'h0);
        wr_reg(rfc_pkg::RFC_OFS_TRG, 32'h1);
        repeat (2) @(posedge clk_i);
        cmp_val("ref driving", 32'h0, {31'h0, ref_oe_n});
        wait_irq();
        rd_reg(rfc_pkg::RFC_OFS_INTF, v);
        cmp_val("ref done flag", 32'h1, v);
        rd_reg(rfc_pkg::RFC_OFS_TRG, v);
        cmp_val("ref stopped", 32'h0, v);
        rd_reg(rfc_pkg::RFC_OFS_MC, v);
        cmp_val("mc wrapped", 32'h0, v);
        wr_reg(rfc_pkg::RFC_OFS_INTF, 32'h1f);
        wr_reg(rfc_pkg::RFC_OFS_TRG, 32'h2);
        wait_irq();
        rd_reg(rfc_pkg::RFC_OFS_INTF, v);
        cmp_val("sensor a flag", 32'h2, v);
        rd_reg(rfc_pkg::RFC_OFS_TC, v);
        cmp_val("tc down to zero", 32'h0, v);
        rd_reg(rfc_pkg::RFC_OFS_MC, v);
        cmp_near("difference", 32'h10, v);
        wr_reg(rfc_pkg::RFC_OFS_INTF, 32'h1f);
        wr_reg(rfc_pkg::RFC_OFS_MC, 32'h0);
        wr_reg(rfc_pkg::RFC_OFS_TC, 32'h00fffff0);
        wr_reg(rfc_pkg::RFC_OFS_TRG, 32'h1);
        wait_irq();
        rd_reg(rfc_pkg::RFC_OFS_INTF, v);
        cmp_val("tc overflow flag", 32'h10, v);
        rd_reg(rfc_pkg::RFC_OFS_TRG, v);
        cmp_val("ref stopped", 32'h0, v);
        wr_reg(rfc_pkg::RFC_OFS_INTF, 32'h1f);
        wr_reg(rfc_pkg::RFC_OFS_CLK, 32'h131);
        wr_reg(rfc_pkg::RFC_OFS_TC, 32'h0);
        wr_reg(rfc_pkg::RFC_OFS_TRG, 32'h1);
        dbg <= 1'b1;
        repeat (79) @(posedge clk_i);
        dbg <= 1'b0;
        wr_reg(rfc_pkg::RFC_OFS_TRG, 32'h0);
        rd_reg(rfc_pkg::RFC_OFS_TC, v);
        cmp_near("divided count", 32'ha, v);
        wr_reg(rfc_pkg::RFC_OFS_CLK, 32'h031);
        wr_reg(rfc_pkg::RFC_OFS_TC, 32'h0);
        wr_reg(rfc_pkg::RFC_OFS_TRG, 32'h1);
        repeat (16) @(posedge clk_i);
        dbg <= 1'b1;
        rd_reg(rfc_pkg::RFC_OFS_TC, t1);
        repeat (40) @(posedge clk_i);
        rd_reg(rfc_pkg::RFC_OFS_TC, v);
        cmp_val("tc held", t1, v);
        cmp_val("pin held", 32'h0, {31'h0, ref_oe_n});
        dbg <= 1'b0;
        repeat (24) @(posedge clk_i);
        rd_reg(rfc_pkg::RFC_OFS_TC, v);
        cmp_val("tc resumed", 32'h1, {31'h0, v > t1});
        wr_reg(rfc_pkg::RFC_OFS_TRG, 32'h0);
        wr_reg(rfc_pkg::RFC_OFS_CTL, 32'h9);
        repeat (2) @(posedge clk_i);
        cmp_val("monitor drives", 32'h0, {31'h0, mon_oe_n});
        wr_reg(rfc_pkg::RFC_OFS_CTL, 32'h5);
        wr_reg(rfc_pkg::RFC_OFS_MC, 32'h0);
        wr_reg(rfc_pkg::RFC_OFS_TRG, 32'h1);
        repeat (29) @(posedge clk_i);
        cmp_val("ext ref hi-z", 32'h1, {31'h0, ref_oe_n});
        wr_reg(rfc_pkg::RFC_OFS_TRG, 32'h0);
        rd_reg(rfc_pkg::RFC_OFS_MC, v);
        cmp_near("ext count", 32'h5, v);
        wr_reg(rfc_pkg::RFC_OFS_CTL, 32'h11);
        wr_reg(rfc_pkg::RFC_OFS_TC, 32'h00fff000);
        wr_reg(rfc_pkg::RFC_OFS_TRG, 32'h4);
        rd_reg(rfc_pkg::RFC_OFS_TRG, v);
        cmp_val("ac sensor b refused", 32'h0, v);
        wr_reg(rfc_pkg::RFC_OFS_TRG, 32'h2);
        rd_reg(rfc_pkg::RFC_OFS_TRG, v);
        cmp_val("ac sensor a runs", 32'h2, v);
        wr_reg(rfc_pkg::RFC_OFS_TRG, 32'h0);
        print_verdict();
    end
endmodule // tb_rf_converter_counter_control
